// ### logic/relsel_top.sv
`timescale 1ns/10ps
`default_nettype none
module relsel_top #(
  parameter int DATA_W = relsel_pkg::RELSEL_DATA_W,
  parameter int TRIES_W = relsel_pkg::RELSEL_TRIES_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [relsel_pkg::RELSEL_SEL_W-1:0] relaySel,
  input wire relsel_pkg::relsel_status_t status,
  input wire relsel_pkg::relsel_meas_t meas,
  input wire logic thresholdWrite,
  input wire logic [DATA_W-1:0] thresholdData,
  input wire logic [TRIES_W-1:0] restartTryLimit,
  input wire logic [TRIES_W-1:0] restartTryCount,
  input wire logic [15:0] logicCmdWord,
  output logic [DATA_W-1:0] relayThreshold,
  output logic relayOut
);
  import relsel_pkg::*;

  logic [DATA_W-1:0] threshold_reg;
  logic relay_reg;
  logic relay_next;
  logic [3:0] aboveVec;
  logic [DATA_W-1:0] measVec [4];
  logic triesExceeded;
  logic unrecoverable;
  logic netRelay;

  assign measVec[0] = meas.outFreq;
  assign measVec[1] = meas.outCurrPct;
  assign measVec[2] = meas.busVolt;
  assign measVec[3] = meas.analogVolt;

  // One comparator per measurement, all against the one shared threshold.
  for (genvar i = 0; i < 4; i++) begin : g_cmp
    relsel_cmp #(.W(DATA_W)) u_cmp (
      .value(measVec[i]),
      .threshold(threshold_reg),
      .above(aboveVec[i])
    );
  end

  assign triesExceeded = restartTryCount > restartTryLimit;
  assign unrecoverable = triesExceeded || (!status.autoRestartEn && status.faultActive)
    || status.nonResetFault;
  // The low bit of the stored level doubles as the network on/off value.
  assign netRelay = threshold_reg[0];

  always_comb begin
    unique case (relaySel)
      SEL_FREQ_REACHED: relay_next = status.freqReached;
      SEL_MOTOR_POWERED: relay_next = status.motorPowered;
      SEL_REVERSE: relay_next = status.reverseCmd;
      SEL_OVERLOAD: relay_next = status.overload;
      SEL_RAMP_REG: relay_next = status.rampReg;
      SEL_FREQ_OVER: relay_next = aboveVec[0];
      SEL_CURR_OVER: relay_next = aboveVec[1];
      SEL_BUSVOLT_OVER_THRESHOLD: relay_next = aboveVec[2];
      SEL_TRIES_EXCEEDED: relay_next = triesExceeded;
      SEL_ANALOG_OVER: relay_next = aboveVec[3];
      SEL_NETWORK_DRIVEN: relay_next = netRelay;
      SEL_UNRECOVERABLE_FAULT: relay_next = unrecoverable;
      SEL_CMD_WORD: relay_next = logicCmdWord[CMD_RELAY_BIT];
      // Unused codes keep the relay released as a safe state.
      default: relay_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_reg <= DATA_W'(THRESHOLD_RESET);
      relay_reg <= RELAY_RESET;
    end else if (clkEn) begin
      if (thresholdWrite) begin
        threshold_reg <= thresholdData;
      end
      relay_reg <= relay_next;
    end
  end

  assign relayOut = relay_reg;
  assign relayThreshold = threshold_reg;

  property p_freq_over;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_FREQ_OVER && meas.outFreq > threshold_reg) |=> relayOut;
  endproperty
  a_freq_over: assert property (p_freq_over) else $error("freq over threshold not energised");

  property p_curr_eq;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_CURR_OVER && meas.outCurrPct <= threshold_reg) |=> !relayOut;
  endproperty
  a_curr_eq: assert property (p_curr_eq) else $error("current not above but energised");

  property p_bus;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_BUSVOLT_OVER_THRESHOLD) |=> relayOut == $past(meas.busVolt > threshold_reg);
  endproperty
  a_bus: assert property (p_bus) else $error("bus voltage relay mismatch");

  property p_analog;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_ANALOG_OVER) |=> relayOut == $past(meas.analogVolt > threshold_reg);
  endproperty
  a_analog: assert property (p_analog) else $error("analog relay mismatch");

  property p_tries;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_TRIES_EXCEEDED) |=> relayOut == $past(restartTryCount > restartTryLimit);
  endproperty
  a_tries: assert property (p_tries) else $error("tries relay mismatch");

  sequence s_net_write;
    clkEn && thresholdWrite && relaySel == SEL_NETWORK_DRIVEN;
  endsequence
  sequence s_net_hold;
    clkEn && relaySel == SEL_NETWORK_DRIVEN && !thresholdWrite;
  endsequence
  property p_net;
    @(posedge clk) disable iff (!rst_n)
      s_net_write ##1 s_net_hold |=> relayOut == $past(thresholdData[0], 2);
  endproperty
  a_net: assert property (p_net) else $error("network write did not drive relay");

  property p_fault;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_UNRECOVERABLE_FAULT && status.nonResetFault) |=> relayOut;
  endproperty
  a_fault: assert property (p_fault) else $error("unrecoverable fault not energised");

  property p_cmd;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_CMD_WORD) |=> relayOut == $past(logicCmdWord[CMD_RELAY_BIT]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command bit relay mismatch");

  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      !clkEn |=> $stable(relayOut) && $stable(relayThreshold);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state changed with enable low");

  property p_status;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && relaySel == SEL_OVERLOAD) |=> relayOut == $past(status.overload);
  endproperty
  a_status: assert property (p_status) else $error("overload relay mismatch");
endmodule
`default_nettype wire

// ### logic/relsel_pkg.sv
package relsel_pkg;
  localparam int RELSEL_DATA_W = 16;
  localparam int RELSEL_SEL_W = 4;
  localparam int RELSEL_TRIES_W = 8;
  localparam logic [RELSEL_SEL_W-1:0] SEL_FREQ_REACHED = 4'h1;
  localparam logic [RELSEL_SEL_W-1:0] SEL_MOTOR_POWERED = 4'h2;
  localparam logic [RELSEL_SEL_W-1:0] SEL_REVERSE = 4'h3;
  localparam logic [RELSEL_SEL_W-1:0] SEL_OVERLOAD = 4'h4;
  localparam logic [RELSEL_SEL_W-1:0] SEL_RAMP_REG = 4'h5;
  localparam logic [RELSEL_SEL_W-1:0] SEL_FREQ_OVER = 4'h6;
  localparam logic [RELSEL_SEL_W-1:0] SEL_CURR_OVER = 4'h7;
  localparam logic [RELSEL_SEL_W-1:0] SEL_BUSVOLT_OVER_THRESHOLD = 4'h8;
  localparam logic [RELSEL_SEL_W-1:0] SEL_TRIES_EXCEEDED = 4'h9;
  localparam logic [RELSEL_SEL_W-1:0] SEL_ANALOG_OVER = 4'ha;
  localparam logic [RELSEL_SEL_W-1:0] SEL_NETWORK_DRIVEN = 4'hb;
  localparam logic [RELSEL_SEL_W-1:0] SEL_UNRECOVERABLE_FAULT = 4'hc;
  localparam logic [RELSEL_SEL_W-1:0] SEL_CMD_WORD = 4'hd;
  localparam int CMD_RELAY_BIT = 6;
  localparam logic RELAY_RESET = 1'b0;
  localparam logic [RELSEL_DATA_W-1:0] THRESHOLD_RESET = 16'h0000;

  typedef struct packed {
    logic freqReached;
    logic motorPowered;
    logic reverseCmd;
    logic overload;
    logic rampReg;
    logic autoRestartEn;
    logic faultActive;
    logic nonResetFault;
  } relsel_status_t;

  typedef struct packed {
    logic [RELSEL_DATA_W-1:0] outFreq;
    logic [RELSEL_DATA_W-1:0] outCurrPct;
    logic [RELSEL_DATA_W-1:0] busVolt;
    logic [RELSEL_DATA_W-1:0] analogVolt;
  } relsel_meas_t;
endpackage

// ### logic/relsel_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module relsel_cmp #(
  parameter int W = 16
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] threshold,
  output logic above
);
  assign above = value > threshold;
endmodule
`default_nettype wire

// ### dv/relsel_relay_model.sv
`timescale 1ns/10ps
`default_nettype none
// The contact follows the coil one control cycle late, as a real relay lags its drive.
module relsel_relay_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic coilDrive,
  output logic contactClosed
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      contactClosed <= 1'b0;
    end else begin
      contactClosed <= coilDrive;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import relsel_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] relaySel = 4'h0;
  relsel_status_t status = '0;
  relsel_meas_t meas = '0;
  logic thresholdWrite = 1'b0;
  logic [15:0] thresholdData = 16'h0000;
  logic [7:0] restartTryLimit = 8'h03;
  logic [7:0] restartTryCount = 8'h00;
  logic [15:0] logicCmdWord = 16'h0000;
  logic [15:0] relayThreshold;
  logic relayOut;
  logic contactClosed;
  logic [3:0] cmpSel [4] = '{4'h6, 4'h7, 4'h8, 4'ha};
  int mismatches = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  relsel_top i_relsel_top (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .relaySel(relaySel), .status(status),
    .meas(meas), .thresholdWrite(thresholdWrite), .thresholdData(thresholdData),
    .restartTryLimit(restartTryLimit), .restartTryCount(restartTryCount), .logicCmdWord(logicCmdWord),
    .relayThreshold(relayThreshold), .relayOut(relayOut));
  relsel_relay_model i_relsel_relay_model (.clk(clk), .rst_n(rst_n), .coilDrive(relayOut),
    .contactClosed(contactClosed));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic [3:0] sel, input logic [7:0] st, input logic exp);
    relaySel = sel;
    status = st;
    @(posedge clk);
    #1;
    cmp({15'h0000, relayOut}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [15:0] d);
    thresholdWrite = 1'b1;
    thresholdData = d;
    @(posedge clk);
    #1;
    thresholdWrite = 1'b0;
  endtask
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp(relayThreshold, 16'h0000);
    cmp({15'h0000, relayOut}, 16'h0000);
    wr(16'h0064);
    cmp(relayThreshold, 16'h0064);
    for (int c = 1; c <= 5; c++) begin
      step(4'(c), 8'h80 >> (c - 1), 1'b1);
      step(4'(c), ~(8'h80 >> (c - 1)), 1'b0);
    end
    $display("status codes done");
    for (int k = 0; k < 4; k++) begin
      // Other fields sit high so that a wrong field pick energises the relay.
      meas = '1;
      meas[63-16*k -: 16] = 16'h0064;
      step(cmpSel[k], 8'h00, 1'b0);
      meas = '0;
      meas[63-16*k -: 16] = 16'h0065;
      step(cmpSel[k], 8'h00, 1'b1);
    end
    $display("threshold codes done");
    restartTryCount = 8'h03;
    step(4'h9, 8'h00, 1'b0);
    restartTryCount = 8'h04;
    step(4'h9, 8'h00, 1'b1);
    step(4'hc, 8'h00, 1'b1);
    restartTryCount = 8'h00;
    step(4'hc, 8'h00, 1'b0);
    step(4'hc, 8'h02, 1'b1);
    step(4'hc, 8'h06, 1'b0);
    step(4'hc, 8'h01, 1'b1);
    logicCmdWord = 16'h0040;
    step(4'hd, 8'h00, 1'b1);
    logicCmdWord = 16'hffbf;
    step(4'hd, 8'h00, 1'b0);
    $display("fault and command codes done");
    relaySel = 4'hb;
    wr(16'h0001);
    step(4'hb, 8'h00, 1'b1);
    wr(16'h0000);
    cmp({15'h0000, relayOut}, 16'h0001);
    cmp({15'h0000, contactClosed}, 16'h0001);
    step(4'hb, 8'h00, 1'b0);
    logicCmdWord = 16'hffff;
    meas = '1;
    step(4'h0, 8'hff, 1'b0);
    step(4'he, 8'hff, 1'b0);
    step(4'hf, 8'hff, 1'b0);
    clkEn = 1'b0;
    // The command bit is high, so a relay that ignores the enable would close here.
    relaySel = 4'hd;
    wr(16'h0001);
    cmp(relayThreshold, 16'h0000);
    cmp({15'h0000, relayOut}, 16'h0000);
    clkEn = 1'b1;
    $display("network and undefined codes done");
    step(4'hd, 8'h00, 1'b1);
    wr(16'h00a5);
    cmp(relayThreshold, 16'h00a5);
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp(relayThreshold, 16'h0000);
    cmp({15'h0000, relayOut}, 16'h0000);
    $display("mid-run reset done");
    results();
  end
endmodule
`default_nettype wire
